// [hw/led_indicator_pkg.sv]
// Purpose: constants and types for the second-lamp indicator controller
// Assumes: 40 MHz pclk, 32-bit APB, register index times four is the byte address
// Notes: blink rates are in milliseconds of a 1 ms time base
package led_indicator_pkg;
	localparam int          CLK_HZ          = 40_000_000;
	localparam int          TICK_TIME_US    = 1000;
	localparam int          MS_TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_TIME_US;
	localparam int          MIN_ON_MS       = 10;
	// one extra tick: the first tick may arrive right after the load
	localparam int          MIN_ON_TICKS    = MIN_ON_MS + 1;
	localparam int          LEVEL_WINDOW_MS = 1000;
	localparam int          LEVEL_UNIT_MS   = 42;

	localparam int          ADDR_W          = 18;
	localparam logic [15:0] IDX_LEVEL_CFG   = 16'h40c1;
	localparam logic [15:0] IDX_BLINK_RATE  = 16'h40c2;
	localparam logic [15:0] IDX_LED_CTRL    = 16'h40c3;
	localparam logic [15:0] IDX_LED_STATUS  = 16'h40c4;

	// led_second_output_control fields
	localparam int          FORCE_EN_BIT    = 15;
	localparam int          FORCE_SEL_LSB   = 13;
	localparam int          ACT_IND_BIT     = 12;
	localparam int          RX_BLK_BIT      = 8;
	localparam int          TX_ON_BIT       = 7;
	localparam int          RX_ON_BIT       = 6;
	localparam int          FAST_ON_BIT     = 5;
	localparam int          SLOW_ON_BIT     = 4;
	localparam int          COL_BLK_BIT     = 3;
	localparam int          FAST_BLK_BIT    = 2;
	localparam int          SLOW_BLK_BIT    = 1;
	localparam logic [15:0] LED_CTRL_RESET  = 16'h0120;
	localparam logic [15:0] LED_CTRL_WMASK  = 16'hf1fe;

	// led_blink_rate_select: mode0 15:12, mode1 11:8, mode2 7:4, mode3 3:0
	localparam logic [15:0] BLINK_RATE_RESET = 16'hec75;

	// level configuration: select 6, level enable 5, threshold 4:0
	localparam int          COL_SEL_BIT     = 6;
	localparam int          LEVEL_EN_BIT    = 5;
	localparam logic [15:0] LEVEL_CFG_RESET = 16'h004c;
	localparam logic [15:0] LEVEL_CFG_WMASK = 16'h007f;

	typedef logic [13:0] ms_count_t;
	typedef enum logic [1:0] {FORCE_OFF, FORCE_ON, FORCE_BLINK1, FORCE_BLINK0} force_sel_t;

	// full period in ms for each rate code
	function automatic ms_count_t rate_period_ms(input logic [3:0] code);
		ms_count_t p [16] = '{14'd10000, 14'd9400, 14'd8000, 14'd6000, 14'd4000, 14'd3000,
			14'd2000, 14'd1500, 14'd1000, 14'd800, 14'd600, 14'd400, 14'd250, 14'd200,
			14'd125, 14'd100};
		return p[code];
	endfunction : rate_period_ms

	// share of the period spent dark, in percent
	function automatic logic [6:0] rate_off_pct(input logic [3:0] code);
		logic [6:0] o [16] = '{7'd6, 7'd7, 7'd10, 7'd10, 7'd20, 7'd20, 7'd30, 7'd30,
			7'd40, 7'd40, 7'd50, 7'd50, 7'd50, 7'd50, 7'd50, 7'd50};
		return o[code];
	endfunction : rate_off_pct
endpackage : led_indicator_pkg

// [hw/link_led_indicator_control.sv]
// Purpose: drives the second indicator lamp from link state, activity and software
// Assumes: status inputs synchronous to pclk, APB slave with zero wait states
// Notes: lamp output is active high, registered
//
// Summary of operation
// - rate field 11:8 sets blink mode 1, reset twelve
// - rate field 7:4 sets blink mode 2, reset seven
// - rate field 3:0 sets blink mode 3, reset five
// - bit 15 enables force; select 14:13 otherwise ignored
// - force select: off, on, mode1 blink, mode0 blink
// - receive activity blinks by traffic weight, gated
// - transmit activity lights lamp at least 10 ms
// - receive activity lights lamp at least 10 ms
// - bit 5 lights lamp at 100 Mb/s link
// - bit 4 lights lamp at 10 Mb/s link
// - bit 3 blinks lamp on fast-link collisions
// - bit 2 blinks mode 2 at 100 Mb/s
// - bit 1 blinks mode 3 at 10 Mb/s
// - rate code 0 slow, 14 is 8 Hz, 15 is 10 Hz
// - collision select one uses mode 0, zero mode 1
// - traffic heavy above threshold times 42 ms per second
// - level enable picks mode 0 for heavy traffic
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module link_led_indicator_control
	import led_indicator_pkg::*;
#(
	parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              link_up,
	input  wire logic              speed_fast,
	input  wire logic              rx_active,
	input  wire logic              tx_active,
	input  wire logic              collision,
	output logic                   led_on
);
	logic [15:0] led_second_output_control;
	logic [15:0] led_blink_rate_select;
	logic [15:0] level_config;
	logic [15:0] status_word;
	logic [15:0] tick_count;
	logic        ms_tick;
	logic [3:0]  wave;
	logic [10:0] rx_window_ms;
	logic [10:0] tx_window_ms;
	logic [9:0]  window_ms;
	logic        rx_heavy;
	logic        tx_heavy;
	logic [3:0]  rx_hold;
	logic [3:0]  tx_hold;
	logic        next_led;

	// apb slave
	logic        setup;
	logic        wr_access;
	logic        hit_ctrl;
	logic        hit_rate;
	logic        hit_cfg;
	logic        hit_stat;
	logic        mapped;
	logic [15:0] wdata16;
	logic [15:0] byte_mask;

	// the low two address bits must be zero; unaligned bytes do not decode
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign hit_ctrl  = paddr == {IDX_LED_CTRL, 2'b00};
	assign hit_rate  = paddr == {IDX_BLINK_RATE, 2'b00};
	assign hit_cfg   = paddr == {IDX_LEVEL_CFG, 2'b00};
	assign hit_stat  = paddr == {IDX_LED_STATUS, 2'b00};
	assign mapped    = hit_ctrl || hit_rate || hit_cfg || hit_stat;
	assign wdata16   = pwdata[15:0];
	assign byte_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	// pstrb[3:2] ignored: every register is sixteen bits wide
	// zero wait states; unmapped addresses and status writes report an error
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && (!mapped || (pwrite && hit_stat));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_second_output_control <= LED_CTRL_RESET;
		end else if (wr_access && hit_ctrl) begin
			led_second_output_control <= (led_second_output_control & ~(byte_mask
				& LED_CTRL_WMASK)) | (wdata16 & byte_mask & LED_CTRL_WMASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_blink_rate_select <= BLINK_RATE_RESET;
		end else if (wr_access && hit_rate) begin
			// a new rate keeps the running phase; it wraps at the new period
			led_blink_rate_select <= (led_blink_rate_select & ~byte_mask)
				| (wdata16 & byte_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_config <= LEVEL_CFG_RESET;
		end else if (wr_access && hit_cfg) begin
			level_config <= (level_config & ~(byte_mask & LEVEL_CFG_WMASK))
				| (wdata16 & byte_mask & LEVEL_CFG_WMASK);
		end
	end

	// live view for software, not latched; bits 15:8 read as zero
	assign status_word = {8'h00, rx_hold != 4'h0, tx_hold != 4'h0, rx_heavy, tx_heavy,
		wave};

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (1'b1)
				hit_ctrl: prdata <= {16'h0000, led_second_output_control};
				hit_rate: prdata <= {16'h0000, led_blink_rate_select};
				hit_cfg:  prdata <= {16'h0000, level_config};
				hit_stat: prdata <= {16'h0000, status_word};
				default:  prdata <= 32'h0000_0000;
			endcase
		end
	end

	// 1 ms time base, shared so all waveforms and holds stay in step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= 16'h0000;
			ms_tick    <= 1'b0;
		end else if (tick_count == 16'(TICK_CYCLES - 1)) begin
			tick_count <= 16'h0000;
			ms_tick    <= 1'b1;
		end else begin
			tick_count <= tick_count + 16'h0001;
			ms_tick    <= 1'b0;
		end
	end

	// four blink waveforms; period and dark share come from the rate tables
	for (genvar m = 0; m < 4; m++) begin : g_blink
		logic [3:0]  code;
		ms_count_t   period;
		logic [20:0] dark_scaled;
		ms_count_t   dark_ms;
		ms_count_t   phase;

		// field of mode m sits at bits 15-4m down to 12-4m
		assign code        = led_blink_rate_select[15-4*m -: 4];
		assign period      = rate_period_ms(code);
		assign dark_scaled = 21'(period) * 21'(rate_off_pct(code));
		assign dark_ms     = 14'(dark_scaled / 21'd100);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				phase <= '0;
			end else if (ms_tick) begin
				// a shortened period after a rate change restarts the cycle
				phase <= (phase >= period - 14'd1) ? '0 : phase + 14'd1;
			end
		end

		// lit first, dark for the tail of the period
		// dark share rounds down to whole ms
		assign wave[m] = phase < (period - dark_ms);
	end

	// traffic weight
	// counts clear at the window edge, so each window sees 999 ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_ms    <= '0;
			rx_window_ms <= '0;
			tx_window_ms <= '0;
			rx_heavy     <= 1'b0;
			tx_heavy     <= 1'b0;
		end else if (ms_tick) begin
			if (window_ms == 10'(LEVEL_WINDOW_MS - 1)) begin
				window_ms    <= '0;
				rx_window_ms <= '0;
				tx_window_ms <= '0;
				// judged separately for each direction
				rx_heavy <= rx_window_ms > 11'(level_config[4:0] * LEVEL_UNIT_MS);
				tx_heavy <= tx_window_ms > 11'(level_config[4:0] * LEVEL_UNIT_MS);
			end else begin
				window_ms    <= window_ms + 10'd1;
				rx_window_ms <= rx_window_ms + 11'(rx_active);
				tx_window_ms <= tx_window_ms + 11'(tx_active);
			end
		end
	end

	// minimum on time
	// reloaded while active, so the hold runs from the last active cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hold <= 4'h0;
		end else if (link_up && rx_active) begin
			rx_hold <= 4'(MIN_ON_TICKS);
		end else if (ms_tick && rx_hold != 4'h0) begin
			rx_hold <= rx_hold - 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_hold <= 4'h0;
		end else if (link_up && tx_active) begin
			tx_hold <= 4'(MIN_ON_TICKS);
		end else if (ms_tick && tx_hold != 4'h0) begin
			tx_hold <= tx_hold - 4'h1;
		end
	end

	// lamp decision
	logic       force_en;
	force_sel_t force_sel;
	logic       link_fast;
	logic       link_slow;
	logic       speed_on;
	logic       rx_blink;
	logic       col_blink;
	logic       fast_blink;
	logic       slow_blink;
	logic       any_blink;
	logic       blink_level;
	logic       steady;

	assign force_en  = led_second_output_control[FORCE_EN_BIT];
	assign force_sel = force_sel_t'(led_second_output_control[FORCE_SEL_LSB +: 2]);
	assign link_fast = link_up && speed_fast;
	assign link_slow = link_up && !speed_fast;
	// speed on-condition also gates receive blinking when bit 12 is clear
	assign speed_on  = (led_second_output_control[FAST_ON_BIT] && link_fast)
		|| (led_second_output_control[SLOW_ON_BIT] && link_slow);

	assign rx_blink   = led_second_output_control[RX_BLK_BIT] && link_up && rx_active
		&& (led_second_output_control[ACT_IND_BIT] || speed_on);
	assign col_blink  = led_second_output_control[COL_BLK_BIT] && link_fast
		&& collision;
	assign fast_blink = led_second_output_control[FAST_BLK_BIT] && link_fast;
	assign slow_blink = led_second_output_control[SLOW_BLK_BIT] && link_slow;
	assign any_blink  = rx_blink || col_blink || fast_blink || slow_blink;

	// among blink sources, collision then receive then speed
	// a collision burst stays visible even under heavy receive traffic
	always_comb begin
		if (col_blink) begin
			blink_level = level_config[COL_SEL_BIT] ? wave[0] : wave[1];
		end else if (rx_blink) begin
			blink_level = (level_config[LEVEL_EN_BIT] && rx_heavy) ? wave[0]
				: wave[1];
		end else if (fast_blink) begin
			blink_level = wave[2];
		end else begin
			blink_level = wave[3];
		end
	end

	assign steady = (led_second_output_control[TX_ON_BIT] && tx_hold != 4'h0)
		|| (led_second_output_control[RX_ON_BIT] && rx_hold != 4'h0)
		|| (led_second_output_control[FAST_ON_BIT] && link_fast)
		|| (led_second_output_control[SLOW_ON_BIT] && link_slow);

	always_comb begin
		// force wins even with the link down
		if (force_en) begin
			case (force_sel)
				FORCE_OFF:    next_led = 1'b0;
				FORCE_ON:     next_led = 1'b1;
				FORCE_BLINK1: next_led = wave[1];
				FORCE_BLINK0: next_led = wave[0];
				default:      next_led = 1'b0;
			endcase
		end else if (any_blink) begin
			next_led = blink_level;
		end else begin
			next_led = steady;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_on <= 1'b0;
		end else begin
			// registered so the pin never glitches while sources switch
			led_on <= next_led;
		end
	end
endmodule : link_led_indicator_control

// [tb/led_ctrl_assertions.sv]
// Purpose: port checker for the lamp controller
// Assumes: zero-wait apb slave, byte address is index times four
// Notes: shadows the lamp control register from bus writes
`timescale 1ns/1ps
module led_ctrl_checker
	import led_indicator_pkg::*;
#(
	parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              link_up,
	input wire logic              speed_fast,
	input wire logic              rx_active,
	input wire logic              tx_active,
	input wire logic              collision,
	input wire logic              led_on
);
	logic [15:0] ctrl_s;
	wire         acc_ph = psel & penable;
	wire         a_ctrl = paddr == {IDX_LED_CTRL, 2'b00};
	wire         a_stat = paddr == {IDX_LED_STATUS, 2'b00};
	wire         mapped = a_ctrl | a_stat | (paddr == {IDX_BLINK_RATE, 2'b00})
		| (paddr == {IDX_LEVEL_CFG, 2'b00});
	wire [2:0]   fmode  = ctrl_s[15:13];
	wire         dark_in = !link_up && !ctrl_s[15];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow lets lamp checks follow software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_s <= LED_CTRL_RESET;
		end else if (acc_ph && pwrite && a_ctrl) begin
			if (pstrb[0]) ctrl_s[7:0] <= pwdata[7:0] & LED_CTRL_WMASK[7:0];
			if (pstrb[1]) ctrl_s[15:8] <= pwdata[15:8] & LED_CTRL_WMASK[15:8];
		end
	end
	unmapped_err_a: assert property (acc_ph && !mapped |-> pslverr)
		else $error("unmapped access without error");
	status_write_a: assert property (acc_ph && pwrite && a_stat |-> pslverr)
		else $error("status write without error");
	mapped_read_a: assert property (acc_ph && mapped && !pwrite |-> !pslverr)
		else $error("mapped read flagged");
	ctrl_read_a: assert property (acc_ph && !pwrite && a_ctrl
		|-> prdata == {16'h0000, ctrl_s})
		else $error("control readback wrong");
	upper_zero_a: assert property (acc_ph && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	force_off_a: assert property ($past(fmode) == 3'b100 |-> !led_on)
		else $error("forced off lamp lit");
	force_on_a: assert property ($past(fmode) == 3'b101 |-> led_on)
		else $error("forced on lamp dark");
	link_dark_a: assert property ($past(dark_in) |-> !led_on)
		else $error("lamp lit without link");
	tx_hold_a: assert property ($fell(tx_active) && link_up && ctrl_s == 16'h0080
		|-> ##2 led_on [*8])
		else $error("transmit hold too short");
	ready_zero_wait_a: assert property (acc_ph |-> pready)
		else $error("access phase not ready");
	cover property (acc_ph && !mapped);
	cover property ($rose(led_on));
	cover property (fmode == 3'b111 && led_on);
endmodule : led_ctrl_checker

bind link_led_indicator_control led_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_led_ctrl_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .link_up(link_up), .speed_fast(speed_fast),
	.rx_active(rx_active), .tx_active(tx_active), .collision(collision), .led_on(led_on));

// [tb/testbench.sv]
// Purpose: directed bench for the lamp controller
// Assumes: tick shortened to four clocks per ms
// Notes: blink checks count lit clocks over whole periods, so phase does not matter
`timescale 1ns/1ps
module testbench;
	import led_indicator_pkg::*;
	typedef struct packed {logic [15:0] c; logic s, k, r; int p, e;} case_t;
	localparam int                TK     = 4;
	localparam logic [ADDR_W-1:0] A_LVL  = {IDX_LEVEL_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] A_RATE = {IDX_BLINK_RATE, 2'b00};
	localparam logic [ADDR_W-1:0] A_CTRL = {IDX_LED_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] A_STAT = {IDX_LED_STATUS, 2'b00};
	logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata;
	logic [3:0]        pstrb = 4'hf;
	logic              pready, pslverr, led_on;
	logic              link_up = 0, speed_fast = 1, rx_active = 0, tx_active = 0, collision = 0;
	int                error_cnt = 0, compares = 0;
	// ctrl, fast link, collision, rx, period ms, lit ms
	case_t tbl [15] = '{
		'{16'he020, 1, 0, 0, 100, 50}, '{16'hc020, 1, 0, 0, 200, 100},
		'{16'ha000, 1, 0, 0, 100, 100}, '{16'h8020, 1, 0, 0, 100, 0},
		'{16'h6000, 1, 0, 0, 100, 0}, '{16'h0024, 1, 0, 0, 400, 200},
		'{16'h0010, 1, 0, 0, 100, 0}, '{16'h0010, 0, 0, 0, 100, 100},
		'{16'h0020, 0, 0, 0, 100, 0}, '{16'h0012, 0, 0, 0, 600, 300},
		'{16'h0008, 1, 1, 0, 100, 50}, '{16'h0008, 0, 1, 0, 100, 0},
		'{16'h1100, 1, 0, 1, 200, 100}, '{16'h0120, 1, 0, 1, 200, 100},
		'{16'h0100, 1, 0, 1, 100, 0}};
	always #12.5 pclk = ~pclk;
	link_led_indicator_control #(.TICK_CYCLES(TK)) i_link_led_indicator_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_up(link_up), .speed_fast(speed_fast),
		.rx_active(rx_active), .tx_active(tx_active), .collision(collision), .led_on(led_on));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic ee);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// no wait count assumed; only the watchdog ends a stuck access
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		if (!w) check("prdata", prdata, exp);
		check("pslverr", {31'h0, pslverr}, {31'h0, ee});
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : acc
	task automatic lit(input int per, input int exp);
		int n;
		n = 0;
		repeat (per) @(posedge pclk);
		repeat (per) begin
			@(posedge pclk);
			#1;
			if (led_on === 1'b1) n++;
		end
		check("lit clocks", 32'(n), 32'(exp));
	endtask : lit
	task automatic results;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		results();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		acc(0, A_RATE, 0, 32'h0000_ec75, 0);
		pstrb <= 4'h1;
		acc(1, A_RATE, 32'h0000_fdba, 0, 0);
		pstrb <= 4'hf;
		acc(0, A_RATE, 0, 32'h0000_ecba, 0);
		acc(1, A_RATE, 32'h0000_fdba, 0, 0);
		acc(0, A_RATE, 0, 32'h0000_fdba, 0);
		acc(0, A_CTRL, 0, 32'h0000_0120, 0);
		acc(0, A_LVL, 0, 32'h0000_004c, 0);
		acc(0, 18'h0_0000, 0, 0, 1);
		acc(1, A_STAT, 0, 0, 1);
		#1 check("dark", {31'h0, led_on}, 0);
		@(posedge pclk);
		link_up <= 1;
		repeat (3) @(posedge pclk);
		#1 check("lit", {31'h0, led_on}, 1);
		@(posedge pclk);
		for (int i = 0; i < 15; i++) begin
			speed_fast <= tbl[i].s;
			collision <= tbl[i].k;
			rx_active <= tbl[i].r;
			acc(1, A_CTRL, {16'h0000, tbl[i].c}, 0, 0);
			lit(tbl[i].p * TK, tbl[i].e * TK);
			@(posedge pclk);
		end
		speed_fast <= 1;
		collision <= 1;
		rx_active <= 0;
		acc(1, A_LVL, 32'h0000_000c, 0, 0);
		acc(1, A_CTRL, 32'h0000_0008, 0, 0);
		lit(200 * TK, 100 * TK);
		@(posedge pclk);
		collision <= 0;
		for (int i = 0; i < 2; i++) begin
			acc(1, A_CTRL, i ? 32'h0000_0040 : 32'h0000_0080, 0, 0);
			tx_active <= !i;
			rx_active <= i;
			@(posedge pclk);
			tx_active <= 0;
			rx_active <= 0;
			repeat (39) @(posedge pclk);
			#1 check("hold on", {31'h0, led_on}, 1);
			repeat (12) @(posedge pclk);
			#1 check("hold off", {31'h0, led_on}, 0);
			@(posedge pclk);
		end
		// level enable: threshold 1 (42 ms) is always exceeded, 31 never is
		rx_active <= 1;
		for (int i = 0; i < 2; i++) begin
			acc(1, A_LVL, i ? 32'h0000_003f : 32'h0000_0021, 0, 0);
			acc(1, A_CTRL, 32'h0000_1100, 0, 0);
			repeat (2 * LEVEL_WINDOW_MS * TK) @(posedge pclk);
			lit((i ? 200 : 100) * TK, (i ? 100 : 50) * TK);
			@(posedge pclk);
		end
		rx_active <= 0;
		acc(1, A_CTRL, 32'hffff_ffff, 0, 0);
		acc(0, A_CTRL, 0, 32'h0000_f1fe, 0);
		results();
	end
endmodule : testbench
